// >>> rtl/ril_pkg.sv
// Package with register map, field layout and timing constants of the RTC interrupt logic.
package ril_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [16:0] EVENT_FLAGS_ADDR = 17'h1FFF0;
  localparam logic [16:0] INTERRUPT_CONFIG_ADDR = 17'h1FFF6;
  localparam logic [16:0] IRQ_STATUS_ADDR = 17'h1FF80;
  localparam logic [16:0] IRQ_CLEAR_ADDR = 17'h1FF81;
  localparam logic [16:0] IRQ_ENABLE_ADDR = 17'h1FF82;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int WDF_BIT = 7;
  localparam int AF_BIT = 6;
  localparam int PF_BIT = 5;
  localparam int OSC_FAIL_FLAG_BIT = 4;
  localparam int WIE_BIT = 7;
  localparam int AIE_BIT = 6;
  localparam int PFE_BIT = 5;
  localparam int POL_BIT = 3;
  localparam int PULSE_BIT = 2;

  // Status register layout of the block's own interrupt bits.
  localparam int ST_WD_BIT = 0;
  localparam int ST_AL_BIT = 1;
  localparam int ST_PF_BIT = 2;

  // ---------------------------------------------------------------
  // Reset values and the configuration write mask
  // ---------------------------------------------------------------
  localparam logic [7:0] EVENT_FLAGS_RST = 8'h00;
  localparam logic [7:0] INTERRUPT_CONFIG_RST = 8'h08;
  localparam logic [7:0] CONFIG_WMASK = 8'hEC;
  localparam logic [2:0] IRQ_ENABLE_RST = 3'h0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULSE_MS = 200;
  localparam int PULSE_CYCLES = PULSE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RECALL_US = 20000;
  localparam int RECALL_CYCLES = RECALL_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    RIL_RECALL = 2'b00,
    RIL_IDLE = 2'b01,
    RIL_LEVEL = 2'b10,
    RIL_PULSE = 2'b11
  } ril_state_t;

endpackage

// >>> rtl/ril_rtc_interrupt_logic.sv
// Interrupt logic: event flags, interrupt configuration and the interrupt pin driver.
// ---------------------------------------------------------------
//
// Our own choice: the address-and-strobe port.
module ril_rtc_interrupt_logic
  import ril_pkg::*;
#(
  parameter int PULSE_LEN = PULSE_CYCLES,
  parameter int RECALL_LEN = RECALL_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [16:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic watchdog_timeout_i,
  input wire logic alarm_match_i,
  input wire logic powerfail_i,
  input wire logic backup_power_i,
  input wire logic osc_fail_i,
  input wire logic int_pin_i,
  output logic int_pin_o,
  output logic int_pin_oe_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  // A zero length would wrap the end count to the top of the 32-bit timer and hold its state for about 2**32 cycles.
  if (PULSE_LEN < 1 || RECALL_LEN < 1) begin : g_len_check
    $error("Pulse and recall lengths must be at least one cycle.");
  end

  logic [7:0] flags_ff;
  logic [7:0] config_ff;
  logic [2:0] irq_status_ff;
  logic [2:0] irq_enable_ff;
  logic [31:0] timer_ff;
  ril_state_t state_ff;
  logic [2:0] events;
  logic [2:0] st_events;
  logic [2:0] raised;
  logic flags_read;
  logic active;

  // The pin level is only observed by the bench; the driver does not read it back.
  assign events = {watchdog_timeout_i, alarm_match_i, powerfail_i};
  assign flags_read = rd_i && (addr_i == EVENT_FLAGS_ADDR);

  // The status register keeps its own bit order, independent of the flags register.
  always_comb begin
    st_events = 3'h0;
    st_events[ST_WD_BIT] = watchdog_timeout_i;
    st_events[ST_AL_BIT] = alarm_match_i;
    st_events[ST_PF_BIT] = powerfail_i;
  end

  function automatic logic [2:0] src_flags(input logic [7:0] f);
    src_flags = {f[WDF_BIT], f[AF_BIT], f[PF_BIT]};
  endfunction

  assign raised = src_flags(flags_ff) & {config_ff[WIE_BIT], config_ff[AIE_BIT],
                                         config_ff[PFE_BIT]};

  // ---------------------------------------------------------------
  // Event flags
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      flags_ff <= EVENT_FLAGS_RST;
    end else begin
      // A read clears, but events of the same cycle win and stay set.
      if (flags_read) begin
        flags_ff[WDF_BIT] <= watchdog_timeout_i;
        flags_ff[AF_BIT] <= alarm_match_i;
        flags_ff[PF_BIT] <= powerfail_i;
      end else begin
        flags_ff[WDF_BIT] <= flags_ff[WDF_BIT] | watchdog_timeout_i;
        flags_ff[AF_BIT] <= flags_ff[AF_BIT] | alarm_match_i;
        flags_ff[PF_BIT] <= flags_ff[PF_BIT] | powerfail_i;
      end
      flags_ff[OSC_FAIL_FLAG_BIT] <= osc_fail_i;
    end
  end

  // Flags are set by their sources alone; the enables only steer the pin.
  a_af_sets: assert property (@(posedge clk_i) disable iff (reset_i)
    alarm_match_i |=> flags_ff[AF_BIT])
    else $error("Alarm flag not set.");
  a_pf_sets: assert property (@(posedge clk_i) disable iff (reset_i)
    powerfail_i |=> flags_ff[PF_BIT])
    else $error("Power-fail flag not set.");
  a_osc_follows: assert property (@(posedge clk_i) disable iff (reset_i)
    1'b1 |=> flags_ff[OSC_FAIL_FLAG_BIT] == $past(osc_fail_i))
    else $error("Oscillator flag does not follow its input.");
  a_flags_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(reset_i) |-> src_flags(flags_ff) == 3'h0)
    else $error("Flags not zero after reset.");

  // ---------------------------------------------------------------
  // Configuration and interrupt status registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      config_ff <= INTERRUPT_CONFIG_RST;
      irq_enable_ff <= IRQ_ENABLE_RST;
    end else if (wr_i) begin
      if (addr_i == INTERRUPT_CONFIG_ADDR) begin
        config_ff <= wdata_i & CONFIG_WMASK;
      end else if (addr_i == IRQ_ENABLE_ADDR) begin
        irq_enable_ff <= wdata_i[2:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_status_ff <= 3'h0;
    end else if (wr_i && addr_i == IRQ_CLEAR_ADDR) begin
      irq_status_ff <= (irq_status_ff & ~wdata_i[2:0]) | st_events;
    end else begin
      irq_status_ff <= irq_status_ff | st_events;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status_ff & irq_enable_ff);
    end
  end

  // An event in the cycle of a clear write must survive it, or it would be lost unseen.
  a_status_sticky: assert property (@(posedge clk_i) disable iff (reset_i)
    |st_events |=> (irq_status_ff & $past(st_events)) == $past(st_events))
    else $error("Status event lost.");
  a_status_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_i && addr_i == IRQ_CLEAR_ADDR && !(|st_events)
      |=> (irq_status_ff & $past(wdata_i[2:0])) == 3'h0)
    else $error("Status bits not cleared.");
  a_irq_high: assert property (@(posedge clk_i) disable iff (reset_i)
    |(irq_status_ff & irq_enable_ff) |=> irq_o)
    else $error("Interrupt output not raised.");

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      if (addr_i == EVENT_FLAGS_ADDR) begin
        rdata_o <= flags_ff;
      end else if (addr_i == INTERRUPT_CONFIG_ADDR) begin
        rdata_o <= config_ff;
      end else if (addr_i == IRQ_STATUS_ADDR) begin
        rdata_o <= {5'h00, irq_status_ff};
      end else if (addr_i == IRQ_ENABLE_ADDR) begin
        rdata_o <= {5'h00, irq_enable_ff};
      end else begin
        rdata_o <= 8'h00;
      end
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // Pin driver state machine
  // ---------------------------------------------------------------
  // A flag still set after a pulse of full length does not retrigger; only a new read rearms it.
  logic pulse_done_ff;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_ff <= RIL_RECALL;
      timer_ff <= 32'h0;
      pulse_done_ff <= 1'b0;
    end else begin
      case (state_ff)
        RIL_RECALL: begin
          if (timer_ff == 32'(RECALL_LEN - 1)) begin
            state_ff <= RIL_IDLE;
            timer_ff <= 32'h0;
          end else begin
            timer_ff <= timer_ff + 32'h1;
          end
        end
        RIL_IDLE: begin
          if (flags_read) begin
            pulse_done_ff <= 1'b0;
          end else if (|raised && !backup_power_i && !pulse_done_ff) begin
            if (config_ff[PULSE_BIT]) begin
              state_ff <= RIL_PULSE;
              timer_ff <= 32'h0;
            end else begin
              state_ff <= RIL_LEVEL;
            end
          end
        end
        RIL_LEVEL: begin
          if (flags_read || backup_power_i) begin
            state_ff <= RIL_IDLE;
          end
        end
        RIL_PULSE: begin
          if (flags_read || backup_power_i) begin
            state_ff <= RIL_IDLE;
          end else if (timer_ff == 32'(PULSE_LEN - 1)) begin
            state_ff <= RIL_IDLE;
            pulse_done_ff <= 1'b1;
          end else begin
            timer_ff <= timer_ff + 32'h1;
          end
        end
        default: begin
          state_ff <= RIL_IDLE;
        end
      endcase
    end
  end

  assign active = (state_ff == RIL_LEVEL) || (state_ff == RIL_PULSE);

  // With POL_BIT set the pin is driven push-pull, active high; with it clear, open-drain low drive releases the pin when inactive and the pull-up is off chip.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      int_pin_o <= 1'b0;
      int_pin_oe_o <= 1'b0;
    end else if (config_ff[POL_BIT]) begin
      int_pin_o <= active;
      int_pin_oe_o <= 1'b1;
    end else begin
      int_pin_o <= 1'b0;
      int_pin_oe_o <= active;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_no_irq_recall: assert property (@(posedge clk_i) disable iff (reset_i)
    state_ff == RIL_RECALL |=> ($past(config_ff[POL_BIT]) ? !int_pin_o : !int_pin_oe_o))
    else $error("Interrupt active during recall.");
  a_needs_enable: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(active) |-> $past(|raised))
    else $error("Interrupt without enabled flag.");
  a_backup_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
    backup_power_i |=> !active)
    else $error("Interrupt on backup power.");
  a_flag_sets: assert property (@(posedge clk_i) disable iff (reset_i)
    watchdog_timeout_i |=> flags_ff[WDF_BIT])
    else $error("Watchdog flag not set.");
  a_read_clears: assert property (@(posedge clk_i) disable iff (reset_i)
    flags_read && !(|events) |=> src_flags(flags_ff) == 3'h0)
    else $error("Flags not cleared by read.");
  a_read_old: assert property (@(posedge clk_i) disable iff (reset_i)
    flags_read |=> rdata_o == $past(flags_ff))
    else $error("Read did not return old flags.");
  a_level_ends: assert property (@(posedge clk_i) disable iff (reset_i)
    state_ff == RIL_LEVEL && flags_read |=> state_ff == RIL_IDLE)
    else $error("Level not ended by read.");
  a_pulse_early: assert property (@(posedge clk_i) disable iff (reset_i)
    state_ff == RIL_PULSE && flags_read |=> state_ff == RIL_IDLE)
    else $error("Pulse not ended by read.");
  a_pol_high: assert property (@(posedge clk_i) disable iff (reset_i)
    config_ff[POL_BIT] && $past(config_ff[POL_BIT]) && !$past(reset_i) |-> int_pin_oe_o)
    else $error("Push-pull drive not enabled.");
  a_pulse_len: assert property (@(posedge clk_i) disable iff (reset_i)
    state_ff == RIL_PULSE && timer_ff == 32'(PULSE_LEN - 1) && !flags_read
      && !backup_power_i |=> state_ff == RIL_IDLE)
    else $error("Pulse did not end on time.");

  // Each source is checked on its own, so a swapped enable bit shows up by name.
  a_wd_drives: assert property (@(posedge clk_i) disable iff (reset_i)
    state_ff == RIL_IDLE && flags_ff[WDF_BIT] && config_ff[WIE_BIT] && !backup_power_i
      && !pulse_done_ff && !flags_read |=> active)
    else $error("Watchdog timeout did not drive the pin.");
  a_al_drives: assert property (@(posedge clk_i) disable iff (reset_i)
    state_ff == RIL_IDLE && flags_ff[AF_BIT] && config_ff[AIE_BIT] && !backup_power_i
      && !pulse_done_ff && !flags_read |=> active)
    else $error("Alarm match did not drive the pin.");
  a_pf_drives: assert property (@(posedge clk_i) disable iff (reset_i)
    state_ff == RIL_IDLE && flags_ff[PF_BIT] && config_ff[PFE_BIT] && !backup_power_i
      && !pulse_done_ff && !flags_read |=> active)
    else $error("Power failure did not drive the pin.");
  a_disabled_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
    state_ff == RIL_IDLE && !(|raised) |=> state_ff == RIL_IDLE)
    else $error("Pin driven without enabled flag.");
  a_level_holds: assert property (@(posedge clk_i) disable iff (reset_i)
    state_ff == RIL_LEVEL && !flags_read && !backup_power_i |=> state_ff == RIL_LEVEL)
    else $error("Level dropped before flags read.");
  a_backup_drop: assert property (@(posedge clk_i) disable iff (reset_i)
    state_ff == RIL_LEVEL && backup_power_i |=> state_ff == RIL_IDLE)
    else $error("Level kept on backup power.");
  a_pulse_holds: assert property (@(posedge clk_i) disable iff (reset_i)
    state_ff == RIL_PULSE && timer_ff != 32'(PULSE_LEN - 1) && !flags_read
      && !backup_power_i |=> state_ff == RIL_PULSE)
    else $error("Pulse ended too early.");
  a_mode_pick: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(active) |-> (state_ff == RIL_PULSE) == $past(config_ff[PULSE_BIT]))
    else $error("Wrong signalling mode chosen.");
  a_pol_low: assert property (@(posedge clk_i) disable iff (reset_i)
    !config_ff[POL_BIT] |=> !int_pin_o && int_pin_oe_o == $past(active))
    else $error("Open-drain drive wrong.");
  // A shorter recall would show pin activity that the host is told to ignore.
  a_recall_len: assert property (@(posedge clk_i) disable iff (reset_i)
    state_ff == RIL_RECALL && timer_ff != 32'(RECALL_LEN - 1) |=> state_ff == RIL_RECALL)
    else $error("Recall ended too early.");
  a_no_retrigger: assert property (@(posedge clk_i) disable iff (reset_i)
    state_ff == RIL_IDLE && pulse_done_ff |=> state_ff == RIL_IDLE)
    else $error("Pulse retriggered without flags read.");
  a_config_mask: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_i && addr_i == INTERRUPT_CONFIG_ADDR |=> config_ff == ($past(wdata_i) & CONFIG_WMASK))
    else $error("Configuration write wrong.");
  a_rdata_idle: assert property (@(posedge clk_i) disable iff (reset_i)
    !rd_i |=> rdata_o == 8'h00)
    else $error("Read data stands too long.");

  c_level: cover property (@(posedge clk_i) state_ff == RIL_LEVEL);
  c_pulse: cover property (@(posedge clk_i) state_ff == RIL_PULSE && flags_read);
  c_pulse_full: cover property (@(posedge clk_i) $rose(pulse_done_ff));
  c_coincide: cover property (@(posedge clk_i) flags_read && |events);
  c_recall_end: cover property (@(posedge clk_i) state_ff == RIL_RECALL ##1 state_ff == RIL_IDLE);

endmodule

// >>> tb/ril_host_model.sv
// Host side model of the interrupt line with its pull-up resistor.
module ril_host_model (
  input wire logic pin_drive_i,
  input wire logic pin_oe_i,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // The pull-up keeps a released open-drain line high, so an idle line never reads as active.
  assign line_o = pin_oe_i ? pin_drive_i : 1'b1;
endmodule

// >>> tb/ril_rtc_interrupt_logic_tb.sv
// Self-checking bench of the RTC interrupt logic.
module ril_rtc_interrupt_logic_tb import ril_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PLEN = 20;
  localparam int RLEN = 10;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [16:0] addr_i = '0;
  logic [7:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [2:0] ev_i = '0;
  logic backup_i = 1'b0;
  logic osc_i = 1'b0;
  logic [7:0] rdata_o;
  logic pin_o;
  logic pin_oe_o;
  logic irq_o;
  logic line;
  logic [7:0] got;
  int mismatches = 0;
  int checked = 0;

  ril_rtc_interrupt_logic #(.PULSE_LEN(PLEN), .RECALL_LEN(RLEN)) i_ril_rtc_interrupt_logic (
    .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .watchdog_timeout_i(ev_i[2]), .alarm_match_i(ev_i[1]),
    .powerfail_i(ev_i[0]), .backup_power_i(backup_i), .osc_fail_i(osc_i), .int_pin_i(line),
    .int_pin_o(pin_o), .int_pin_oe_o(pin_oe_o), .irq_o(irq_o));
  ril_host_model i_ril_host_model (.pin_drive_i(pin_o), .pin_oe_i(pin_oe_o),
    .line_o(line));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // Bus and check helpers
  // ---------------------------------------------------------------
  task automatic op(input logic w, input logic r, input logic [16:0] a, input logic [7:0] d,
                    input logic [2:0] e);
    @(posedge clk_i);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
    ev_i <= e;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    ev_i <= 3'h0;
    #1 got = rdata_o;
  endtask
  task automatic chk(input string n, input logic [7:0] exp, input logic [7:0] seen);
    checked++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", n, exp, seen);
      mismatches++;
    end
  endtask
  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d, 3'h0);
  endtask
  task automatic rd(input logic [16:0] a, input logic [7:0] exp, input logic [2:0] e);
    op(1'b0, 1'b1, a, 8'h00, e);
    chk("rdata", exp, got);
  endtask
  task automatic ev(input logic [2:0] e);
    op(1'b0, 1'b0, 17'h00000, 8'h00, e);
  endtask
  task automatic pin(input logic exp);
    repeat (3) @(posedge clk_i);
    #1 chk("int_line", {7'h00, exp}, {7'h00, line});
  endtask
  task automatic irqc(input logic exp);
    repeat (2) @(posedge clk_i);
    #1 chk("irq", {7'h00, exp}, {7'h00, irq_o});
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd(EVENT_FLAGS_ADDR, EVENT_FLAGS_RST, 3'h0);
    rd(INTERRUPT_CONFIG_ADDR, INTERRUPT_CONFIG_RST, 3'h0);
    rd(17'h1FF90, 8'h00, 3'h0);
    @(posedge clk_i);
    osc_i <= 1'b1;
    rd(EVENT_FLAGS_ADDR, 8'h10, 3'h0);
    @(posedge clk_i);
    osc_i <= 1'b0;
    $display("t_reset done");
  endtask
  task automatic t_sources;
    for (int i = 0; i < 3; i++) begin
      wr(INTERRUPT_CONFIG_ADDR, 8'h08 | (8'h80 >> i));
      ev(3'h4 >> i);
      pin(1'b1);
      pin(1'b1);
      rd(EVENT_FLAGS_ADDR, 8'h80 >> i, 3'h0);
      pin(1'b0);
    end
    $display("t_sources done");
  endtask
  task automatic t_disabled;
    wr(INTERRUPT_CONFIG_ADDR, 8'hFF);
    rd(INTERRUPT_CONFIG_ADDR, CONFIG_WMASK, 3'h0);
    wr(INTERRUPT_CONFIG_ADDR, 8'h08);
    ev(3'h7);
    pin(1'b0);
    rd(EVENT_FLAGS_ADDR, 8'hE0, 3'h2);
    rd(EVENT_FLAGS_ADDR, 8'h40, 3'h0);
    $display("t_disabled done");
  endtask
  task automatic t_pulse;
    wr(INTERRUPT_CONFIG_ADDR, 8'h24);
    ev(3'h1);
    pin(1'b0);
    repeat (PLEN - 6) @(posedge clk_i);
    pin(1'b0);
    repeat (3) @(posedge clk_i);
    pin(1'b1);
    rd(EVENT_FLAGS_ADDR, 8'h20, 3'h0);
    ev(3'h1);
    pin(1'b0);
    rd(EVENT_FLAGS_ADDR, 8'h20, 3'h0);
    pin(1'b1);
    $display("t_pulse done");
  endtask
  task automatic t_backup;
    wr(INTERRUPT_CONFIG_ADDR, 8'h80);
    @(posedge clk_i);
    backup_i <= 1'b1;
    ev(3'h4);
    pin(1'b1);
    rd(EVENT_FLAGS_ADDR, 8'h80, 3'h0);
    @(posedge clk_i);
    backup_i <= 1'b0;
    $display("t_backup done");
  endtask
  task automatic t_irq;
    wr(IRQ_CLEAR_ADDR, 8'h07);
    wr(IRQ_ENABLE_ADDR, 8'h01);
    ev(3'h2);
    irqc(1'b0);
    ev(3'h4);
    irqc(1'b1);
    rd(IRQ_STATUS_ADDR, 8'h03, 3'h0);
    rd(IRQ_ENABLE_ADDR, 8'h01, 3'h0);
    wr(IRQ_CLEAR_ADDR, 8'h01);
    irqc(1'b0);
    rd(IRQ_STATUS_ADDR, 8'h02, 3'h0);
    $display("t_irq done");
  endtask
  task automatic t_recall;
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(EVENT_FLAGS_ADDR, EVENT_FLAGS_RST, 3'h0);
    wr(INTERRUPT_CONFIG_ADDR, 8'h88);
    ev(3'h4);
    pin(1'b0);
    repeat (RLEN) @(posedge clk_i);
    pin(1'b1);
    rd(EVENT_FLAGS_ADDR, 8'h80, 3'h0);
    pin(1'b0);
    $display("t_recall done");
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    // The line is ignored until the recall time has passed.
    repeat (RLEN + 10) @(posedge clk_i);
    t_reset;
    t_sources;
    t_disabled;
    t_pulse;
    t_backup;
    t_irq;
    t_recall;
    end_of_test;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    end_of_test;
  end
endmodule
